//--- cmb_accept_filter.sv
`timescale 1ns/1ps
module cmb_accept_filter
	import cmb_pkg::*;
(
	cmb_rx_if.filt ifc
);

	logic [NUM_BUF-1:0] match;

	// ----------------------------------------------------------------
	// Per-buffer compare: set mask bits are don't-care
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_BUF; i++) begin : g_match
		if (i == BASIC_BUF) begin : g_basic
			assign match[i] = ((ifc.frame_id ^ ifc.buf_id[i]) & ~ifc.basic_mask) == '0; // RULE_02
		end else begin : g_glob
			assign match[i] = ((ifc.frame_id ^ ifc.buf_id[i]) & ~ifc.glob_mask) == '0; // RULE_01
		end
	end

	// Every answering buffer is triggered, not only the first
	assign ifc.remote_hits = match & ifc.tx_elig; // RULE_22

	// ----------------------------------------------------------------
	// First match wins; the basic path only when the low ones miss
	// ----------------------------------------------------------------
	always_comb begin
		logic found;
		found = 1'b0;
		ifc.rx_idx = '0;
		for (int i = 0; i < BASIC_BUF; i++) begin
			if (!found && match[i] && ifc.rx_elig[i]) begin // RULE_07
				found = 1'b1;
				ifc.rx_idx = IDX_W'(i);
			end
		end
		if (!found && match[BASIC_BUF] && ifc.rx_elig[BASIC_BUF]) begin // RULE_03
			found = 1'b1;
			ifc.rx_idx = IDX_W'(BASIC_BUF);
		end
		ifc.rx_hit = found;
	end

endmodule

//--- cmb_can_node.sv
`timescale 1ns/1ps
module cmb_can_node
	import cmb_pkg::*;
(
	input  wire logic          clk_in,
	output logic               cap_out,
	output logic [ID_W-1:0]    id_out,
	output logic [DLC_W-1:0]   dlc_out,
	output logic [DATA_W-1:0]  data_out,
	output logic               eof6_out,
	output logic               done_out,
	output logic [IDX_W-1:0]   sel_out
);
	initial begin
		{cap_out, id_out, dlc_out, data_out, eof6_out, done_out, sel_out} = '0;
	end
	task automatic frame(input logic [ID_W-1:0] id, input logic [DLC_W-1:0] n,
		input logic [DATA_W-1:0] d);
		@(negedge clk_in);
		{cap_out, id_out, dlc_out, data_out} = {1'b1, id, n, d};
		@(negedge clk_in);
		// Lines scrambled after capture so only the hidden copy is valid
		{cap_out, id_out, dlc_out, data_out} = {1'b0, ~id, ~n, ~d};
		repeat (2) @(negedge clk_in);
		eof6_out = 1'b1;
		@(negedge clk_in);
		eof6_out = 1'b0;
	endtask
	task automatic ack(input logic [IDX_W-1:0] i);
		@(negedge clk_in);
		{done_out, sel_out} = {1'b1, i};
		@(negedge clk_in);
		{done_out, sel_out} = {1'b0, ~i};
	endtask
endmodule

//--- cmb_chk_sva.sv
`timescale 1ns/1ps
module cmb_chk
	import cmb_pkg::*;
(
	input  wire logic               CLK_IN,
	input  wire logic               RESETN_IN,
	input  wire logic               RX_EOF6_IN,
	input  wire logic               CPU_WR_IN,
	input  wire logic [NUM_BUF-1:0] RX_INT_ENABLE_IN,
	input  wire logic [NUM_BUF-1:0] RX_INTERRUPT_PENDING_CLEAR_IN,
	input  wire logic               TX_DONE_IN,
	input  wire logic [ST_W-1:0]    RD_STATUS_OUT,
	input  wire logic [NUM_BUF-1:0] TX_REQ_OUT,
	input  wire logic [NUM_BUF-1:0] RX_INTERRUPT_PENDING_OUT,
	input  wire logic               COPY_BUSY_OUT
);
	logic [CNT_W-1:0] run;
	logic [CNT_W-1:0] next_run;

	// Saturates so a long busy run cannot wrap below the limit and fail the length check
	always_comb begin
		next_run = COPY_BUSY_OUT ? run + {4'h0, ~&run} : '0;
	end
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			run <= '0;
		end else begin
			run <= next_run;
		end
	end

	default clocking dc @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	property p_copy_len;
		$fell(COPY_BUSY_OUT) |-> run >= COPY_CYCLES;
	endproperty
	a_copy_len: assert property (p_copy_len) else $error("copy too short");
	property p_copy_cause;
		$rose(COPY_BUSY_OUT) |-> $past(RX_EOF6_IN) || $past(RX_EOF6_IN, 2)
			|| $past(RX_EOF6_IN, 3);
	endproperty
	a_copy_cause: assert property (p_copy_cause) else $error("copy without eof6");
	property p_busy_bit;
		RD_STATUS_OUT[BUSY_BIT] && !RD_STATUS_OUT[TX_BIT]
			|-> (COPY_BUSY_OUT || $past(COPY_BUSY_OUT)) or (##1 COPY_BUSY_OUT);
	endproperty
	a_busy_bit: assert property (p_busy_bit) else $error("busy bit outside copy");
	property p_busy_code;
		RD_STATUS_OUT[BUSY_BIT] |-> RD_STATUS_OUT inside {4'h1, 4'h3, 4'h5, 4'h7, 4'hD, 4'hF};
	endproperty
	a_busy_code: assert property (p_busy_code) else $error("bad busy code");
	property p_pnd_en;
		(RX_INTERRUPT_PENDING_OUT & ~$past(RX_INTERRUPT_PENDING_OUT)
			& ~RX_INT_ENABLE_IN & ~$past(RX_INT_ENABLE_IN)) == '0;
	endproperty
	a_pnd_en: assert property (p_pnd_en) else $error("pending while disabled");
	property p_pnd_copy;
		|(RX_INTERRUPT_PENDING_OUT & ~$past(RX_INTERRUPT_PENDING_OUT))
			|-> COPY_BUSY_OUT || $past(COPY_BUSY_OUT) || $past(COPY_BUSY_OUT, 2);
	endproperty
	a_pnd_copy: assert property (p_pnd_copy) else $error("pending without copy");
	property p_pnd_hold;
		($past(RX_INTERRUPT_PENDING_OUT) & ~RX_INTERRUPT_PENDING_OUT
			& ~$past(RX_INTERRUPT_PENDING_CLEAR_IN) & ~$past(RX_INTERRUPT_PENDING_CLEAR_IN, 2)) == '0;
	endproperty
	a_pnd_hold: assert property (p_pnd_hold) else $error("pending lost");
	property p_tx_drop;
		|($past(TX_REQ_OUT) & ~TX_REQ_OUT) |-> $past(TX_DONE_IN) || $past(TX_DONE_IN, 2)
			|| $past(CPU_WR_IN) || $past(CPU_WR_IN, 2);
	endproperty
	a_tx_drop: assert property (p_tx_drop) else $error("tx request dropped");
endmodule

bind cmb_msg_buffers cmb_chk i_chk (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
	.RX_EOF6_IN(RX_EOF6_IN), .CPU_WR_IN(CPU_WR_IN), .RX_INT_ENABLE_IN(RX_INT_ENABLE_IN),
	.RX_INTERRUPT_PENDING_CLEAR_IN(RX_INTERRUPT_PENDING_CLEAR_IN), .TX_DONE_IN(TX_DONE_IN),
	.RD_STATUS_OUT(RD_STATUS_OUT), .TX_REQ_OUT(TX_REQ_OUT),
	.RX_INTERRUPT_PENDING_OUT(RX_INTERRUPT_PENDING_OUT), .COPY_BUSY_OUT(COPY_BUSY_OUT));

//--- cmb_copy_engine.sv
`timescale 1ns/1ps
module cmb_copy_engine
	import cmb_pkg::*;
(
	input  wire logic clk,
	input  wire logic resetn,
	cmb_rx_if.copier  ifc
);

	typedef struct packed {
		cmb_copy_state_t  state;
		logic [CNT_W-1:0] cnt;
		logic [IDX_W-1:0] idx;
		logic             done;
	} cmb_copy_reg_t;

	localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(COPY_CYCLES - 1);

	cmb_copy_reg_t s;
	cmb_copy_reg_t next_s;

	// ----------------------------------------------------------------
	// Copy slot: active for a fixed count, done on its last cycle
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		unique case (s.state)
			CP_IDLE: begin
				if (ifc.start) begin
					next_s.state = CP_COPY;
					next_s.cnt   = '0;
					next_s.idx   = ifc.start_idx;
				end
			end
			CP_COPY: begin
				if (s.cnt == LAST_CNT) begin // RULE_10
					next_s.state = CP_IDLE;
				end else begin
					next_s.cnt = s.cnt + CNT_W'(1);
					next_s.done = (s.cnt == LAST_CNT - CNT_W'(1));
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '{state: CP_IDLE, cnt: '0, idx: '0, done: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign ifc.active   = (s.state == CP_COPY);
	assign ifc.copy_idx = s.idx;
	assign ifc.done     = s.done;

endmodule

//--- cmb_msg_buffers.sv
`timescale 1ns/1ps
// How it works
// RULE_01: Buffers 0-13 compare identifier bits not masked by the global mask.
// RULE_02: Buffer 14 compares identifier bits not masked by the basic mask.
// RULE_03: Buffer 14 is tried only when none of buffers 0-13 takes the frame.
// RULE_04: With lock on, a filled buffer stays locked until software re-arms it.
// RULE_05: Locked full buffers are skipped; with all locked the frame is dropped.
// RULE_06: Frames wait in a hidden buffer and copy only at the sixth EOF bit.
// RULE_07: A frame goes only into the first matching buffer from buffer 0.
// RULE_08: The copy overwrites identifier, DLC and data with the received ones.
// RULE_09: Armed buffers with RTR set in their identifier store remote frames too.
// RULE_10: Each copy occupies at least seventeen clock cycles.
// RULE_11: The busy bit of the target shows during the copy, clears after it.
// RULE_12: After copy: armed becomes full, full becomes overrun, inactive stays.
// RULE_13: During the copy only status writes reach the buffer; table still applies.
// RULE_14: Codes: inactive 0000, armed 0010, full 0100; writing armed arms it.
// RULE_15: A full buffer receiving again reads 0101 during the copy.
// RULE_16: Armed buffers with interrupt enabled raise pending on becoming full.
// RULE_17: Without lock software re-reads status until stable, then clears pending.
// RULE_18: With lock software reads, re-arms, clears pending; no re-check needed.
// RULE_19: Status top bit set means transmit; inactive transmit accepts all fields.
// RULE_20: Single-send shows busy, returns inactive on success, retries on failure.
// RULE_21: A sent remote request makes the buffer armed for reception.
// RULE_22: Matching remote frames make await buffers send then await again.
// RULE_23: Send-then-await is written 1110, reads 1111 sending; await is 1010.
// RULE_24: Overrun reads 0110, and 0111 while a copy is running.
module cmb_msg_buffers
	import cmb_pkg::*;
(
	input  wire logic                 CLK_IN,
	input  wire logic                 RESETN_IN,
	input  wire logic                 RECEIVE_BUFFER_LOCK_IN,
	input  wire logic [ID_W-1:0]      GLOBAL_ACCEPT_MASK_IN,
	input  wire logic [ID_W-1:0]      BASIC_ACCEPT_MASK_IN,
	input  wire logic                 RX_CAPTURE_IN,
	input  wire logic [ID_W-1:0]      RX_ID_IN,
	input  wire logic [DLC_W-1:0]     RX_DLC_IN,
	input  wire logic [DATA_W-1:0]    RX_DATA_IN,
	input  wire logic                 RX_EOF6_IN,
	input  wire logic                 CPU_WR_IN,
	input  wire logic [IDX_W-1:0]     CPU_SEL_IN,
	input  wire cmb_field_t           CPU_FIELD_IN,
	input  wire logic [DATA_W-1:0]    CPU_WDATA_IN,
	input  wire logic [IDX_W-1:0]     CPU_RD_SEL_IN,
	input  wire logic [NUM_BUF-1:0]   RX_INT_ENABLE_IN,
	input  wire logic [NUM_BUF-1:0]   RX_INTERRUPT_PENDING_CLEAR_IN,
	input  wire logic                 TX_DONE_IN,
	input  wire logic [IDX_W-1:0]     TX_DONE_SEL_IN,
	output logic [ST_W-1:0]           RD_STATUS_OUT,
	output logic [ID_W-1:0]           RD_ID_OUT,
	output logic [DATA_W-1:0]         RD_DATA_OUT,
	output logic [DLC_W-1:0]          RD_DLC_OUT,
	output logic [PRI_W-1:0]          RD_PRI_OUT,
	output logic [NUM_BUF-1:0]        TX_REQ_OUT,
	output logic [NUM_BUF-1:0]        RX_INTERRUPT_PENDING_OUT,
	output logic                      COPY_BUSY_OUT
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Every input comes from logic on this clock (protocol core, CPU
	// port), so none of them is synchronised here.
	typedef struct packed {
		logic [ID_W-1:0]            hid_id;
		logic [DLC_W-1:0]           hid_dlc;
		logic [DATA_W-1:0]          hid_data;
		logic                       hid_valid;
		logic                       copy_start;
		logic [IDX_W-1:0]           copy_req;
		cmb_buf_t [NUM_BUF-1:0]     bufs;
		logic [ST_W-1:0]            rd_status;
		logic [ID_W-1:0]            rd_id;
		logic [DATA_W-1:0]          rd_data;
		logic [DLC_W-1:0]           rd_dlc;
		logic [PRI_W-1:0]           rd_pri;
		logic [NUM_BUF-1:0]         tx_req;
		logic [NUM_BUF-1:0]         pnd;
		logic                       busy;
	} cmb_top_reg_t;

	cmb_top_reg_t       s;
	cmb_top_reg_t       next_s;
	logic [NUM_BUF-1:0] busy_vec;

	cmb_rx_if ifc ();

	cmb_accept_filter u_filter (
		.ifc (ifc.filt)
	);

	cmb_copy_engine u_copy (
		.clk    (CLK_IN),
		.resetn (RESETN_IN),
		.ifc    (ifc.copier)
	);

	// ----------------------------------------------------------------
	// Filter inputs and per-buffer busy
	// ----------------------------------------------------------------
	assign ifc.frame_id   = s.hid_id;
	assign ifc.glob_mask  = GLOBAL_ACCEPT_MASK_IN;
	assign ifc.basic_mask = BASIC_ACCEPT_MASK_IN;
	assign ifc.start      = s.copy_start;
	assign ifc.start_idx  = s.copy_req;

	for (genvar i = 0; i < NUM_BUF; i++) begin : g_buf
		logic [ST_W-1:0] ph;
		logic            held;
		assign ph   = s.bufs[i].phase;
		assign held = (ph == ST_RX_FULL) || (ph == ST_RX_OVR);
		assign ifc.buf_id[i] = s.bufs[i].id;
		// Full and overrun buffers still match unless locked
		assign ifc.rx_elig[i] = (ph == ST_RX_ARMED) || (held && !RECEIVE_BUFFER_LOCK_IN) // RULE_05
			;
		assign ifc.tx_elig[i] = (ph == ST_TX_AWAIT) && s.hid_id[RTR_BIT]; // RULE_22
		assign busy_vec[i] = (s.copy_start && s.copy_req == IDX_W'(i))
			|| (ifc.active && ifc.copy_idx == IDX_W'(i)); // RULE_11
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic            blocked;
		logic [ST_W-1:0] ph;
		blocked = 1'b0;
		ph = '0;
		next_s = s;
		next_s.copy_start = 1'b0;

		// Hidden buffer; software cannot reach it
		if (RX_CAPTURE_IN) begin // RULE_06
			next_s.hid_id   = RX_ID_IN;
			next_s.hid_dlc  = RX_DLC_IN;
			next_s.hid_data = RX_DATA_IN;
			next_s.hid_valid = 1'b1;
		end

		// Frame is valid at the sixth EOF bit: pick target and answerers
		// A frame is used once, so a stray EOF6 cannot copy stale contents again
		if (RX_EOF6_IN && s.hid_valid && !ifc.active && !s.copy_start) begin // RULE_06
			next_s.hid_valid = RX_CAPTURE_IN;
			if (ifc.rx_hit) begin // RULE_09
				next_s.copy_start = 1'b1;
				next_s.copy_req   = ifc.rx_idx;
			end
			for (int i = 0; i < NUM_BUF; i++) begin
				if (ifc.remote_hits[i]) begin
					next_s.bufs[i].phase = ST_TX_SEND_AWAIT; // RULE_22
				end
			end
		end

		// CPU writes; a busy buffer only takes status
		for (int i = 0; i < NUM_BUF; i++) begin
			ph = s.bufs[i].phase;
			blocked = busy_vec[i] || (ph == ST_TX_ONCE) || (ph == ST_TX_SEND_AWAIT);
			if (CPU_WR_IN && CPU_SEL_IN == IDX_W'(i)) begin
				unique case (CPU_FIELD_IN)
					FLD_STATUS: begin
						// Busy bit is never stored; transmit busy is derived
						next_s.bufs[i].phase = {CPU_WDATA_IN[ST_LSB+ST_W-1:ST_LSB+1], 1'b0}; // RULE_14
					end
					FLD_ID: begin
						if (!blocked) begin // RULE_13
							next_s.bufs[i].id = CPU_WDATA_IN[ID_W-1:0]; // RULE_19
						end
					end
					FLD_DATA: begin
						if (!blocked) begin // RULE_13
							next_s.bufs[i].data = CPU_WDATA_IN; // RULE_19
						end
					end
					FLD_CTRL: begin
						if (!blocked) begin // RULE_13
							next_s.bufs[i].dlc = CPU_WDATA_IN[DLC_LSB+DLC_W-1:DLC_LSB];
							next_s.bufs[i].tx_priority_value = CPU_WDATA_IN[PRI_LSB+PRI_W-1:PRI_LSB]; // RULE_19
						end
					end
				endcase
			end
		end

		// Transmit success; a failure keeps the buffer busy for retry
		for (int i = 0; i < NUM_BUF; i++) begin
			if (TX_DONE_IN && TX_DONE_SEL_IN == IDX_W'(i)) begin // RULE_20
				if (next_s.bufs[i].phase == ST_TX_ONCE) begin
					if (s.bufs[i].id[RTR_BIT]) begin
						next_s.bufs[i].phase = ST_RX_ARMED; // RULE_21
					end else begin
						next_s.bufs[i].phase = ST_TX_IDLE; // RULE_20
					end
				end else if (next_s.bufs[i].phase == ST_TX_SEND_AWAIT) begin
					next_s.bufs[i].phase = ST_TX_AWAIT; // RULE_22
				end
			end
		end

		// Pending clear first so a same-cycle fill still sets it
		next_s.pnd = s.pnd & ~RX_INTERRUPT_PENDING_CLEAR_IN;

		// Copy end: whole hidden buffer, then the state table on the
		// status as it stands now, including a write made during copy
		for (int i = 0; i < NUM_BUF; i++) begin
			if (ifc.done && ifc.copy_idx == IDX_W'(i)) begin
				next_s.bufs[i].id   = s.hid_id; // RULE_08
				next_s.bufs[i].dlc  = s.hid_dlc; // RULE_08
				next_s.bufs[i].data = s.hid_data;
				unique case (next_s.bufs[i].phase)
					ST_RX_ARMED: begin
						next_s.bufs[i].phase = ST_RX_FULL; // RULE_12
						if (RX_INT_ENABLE_IN[i]) begin
							next_s.pnd[i] = 1'b1; // RULE_16
						end
					end
					ST_RX_FULL: begin
						next_s.bufs[i].phase = ST_RX_OVR; // RULE_24
					end
					default: begin
						next_s.bufs[i].phase = next_s.bufs[i].phase; // RULE_12
					end
				endcase
			end
		end

		// Registered views for the CPU and the transmit side
		for (int i = 0; i < NUM_BUF; i++) begin
			ph = next_s.bufs[i].phase;
			next_s.bufs[i].pnd = next_s.pnd[i];
			next_s.tx_req[i] = (ph == ST_TX_ONCE) || (ph == ST_TX_SEND_AWAIT); // RULE_20
			if (CPU_RD_SEL_IN == IDX_W'(i)) begin
				// Busy reads as bit 0: copy busy or transmit busy
				next_s.rd_status = s.bufs[i].phase | ST_W'(busy_vec[i] // RULE_15
					|| s.bufs[i].phase == ST_TX_ONCE
					|| s.bufs[i].phase == ST_TX_SEND_AWAIT); // RULE_23
				next_s.rd_id   = s.bufs[i].id;
				next_s.rd_data = s.bufs[i].data;
				next_s.rd_dlc  = s.bufs[i].dlc;
				next_s.rd_pri  = s.bufs[i].tx_priority_value;
			end
		end
		next_s.busy = |busy_vec;
	end

	// Locking needs no extra flag: a full buffer leaves the eligible set
	// until software writes the armed code back.
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin // RULE_04
		if (!RESETN_IN) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all from flops
	// ----------------------------------------------------------------
	assign RD_STATUS_OUT            = s.rd_status;
	assign RD_ID_OUT                = s.rd_id;
	assign RD_DATA_OUT              = s.rd_data;
	assign RD_DLC_OUT               = s.rd_dlc;
	assign RD_PRI_OUT               = s.rd_pri;
	assign TX_REQ_OUT               = s.tx_req;
	assign RX_INTERRUPT_PENDING_OUT = s.pnd;
	assign COPY_BUSY_OUT            = s.busy;

endmodule

//--- cmb_pkg.sv
package cmb_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_BUF   = 15;
	localparam int BASIC_BUF = 14;
	localparam int ID_W      = 32;
	localparam int DATA_W    = 64;
	localparam int DLC_W     = 4;
	localparam int PRI_W     = 4;
	localparam int ST_W      = 4;
	localparam int IDX_W     = 4;
	localparam int CNT_W     = 5;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int RTR_BIT   = 0;
	localparam int BUSY_BIT  = 0;
	localparam int TX_BIT    = 3;
	localparam int ST_LSB    = 0;
	localparam int DLC_LSB   = 0;
	localparam int PRI_LSB   = 4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int COPY_CYCLES = 17;

	// ----------------------------------------------------------------
	// Buffer phase codes, busy bit held clear in storage
	// ----------------------------------------------------------------
	localparam logic [ST_W-1:0] ST_RX_IDLE       = 4'h0;
	localparam logic [ST_W-1:0] ST_RX_ARMED      = 4'h2;
	localparam logic [ST_W-1:0] ST_RX_FULL       = 4'h4;
	localparam logic [ST_W-1:0] ST_RX_OVR        = 4'h6;
	localparam logic [ST_W-1:0] ST_TX_IDLE       = 4'h8;
	localparam logic [ST_W-1:0] ST_TX_AWAIT      = 4'hA;
	localparam logic [ST_W-1:0] ST_TX_ONCE       = 4'hC;
	localparam logic [ST_W-1:0] ST_TX_SEND_AWAIT = 4'hE;

	typedef enum logic [1:0] {FLD_STATUS, FLD_ID, FLD_DATA, FLD_CTRL} cmb_field_t;

	typedef enum logic {CP_IDLE, CP_COPY} cmb_copy_state_t;

	typedef struct packed {
		logic [ST_W-1:0]   phase;
		logic [ID_W-1:0]   id;
		logic [DATA_W-1:0] data;
		logic [DLC_W-1:0]  dlc;
		logic [PRI_W-1:0]  tx_priority_value;
		logic              pnd;
	} cmb_buf_t;

endpackage

//--- cmb_rx_if.sv
`timescale 1ns/1ps
interface cmb_rx_if;
	import cmb_pkg::*;

	logic [ID_W-1:0]              frame_id;
	logic [ID_W-1:0]              glob_mask;
	logic [ID_W-1:0]              basic_mask;
	logic [NUM_BUF-1:0][ID_W-1:0] buf_id;
	logic [NUM_BUF-1:0]           rx_elig;
	logic [NUM_BUF-1:0]           tx_elig;
	logic                         rx_hit;
	logic [IDX_W-1:0]             rx_idx;
	logic [NUM_BUF-1:0]           remote_hits;
	logic                         start;
	logic [IDX_W-1:0]             start_idx;
	logic                         active;
	logic [IDX_W-1:0]             copy_idx;
	logic                         done;

	modport filt (input frame_id, glob_mask, basic_mask, buf_id, rx_elig, tx_elig,
		output rx_hit, rx_idx, remote_hits);
	modport copier (input start, start_idx, output active, copy_idx, done);
	modport ctrl (output frame_id, glob_mask, basic_mask, buf_id, rx_elig, tx_elig,
		start, start_idx, input rx_hit, rx_idx, remote_hits, active, copy_idx, done);

endinterface

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import cmb_pkg::*;
	logic               clk;
	logic               rstn;
	logic               lock;
	logic [ID_W-1:0]    gm;
	logic [ID_W-1:0]    bm;
	logic               wr;
	logic [IDX_W-1:0]   sel;
	cmb_field_t         fld;
	logic [DATA_W-1:0]  wd;
	logic [IDX_W-1:0]   rsel;
	logic [NUM_BUF-1:0] ie;
	logic [NUM_BUF-1:0] pclr;
	logic               cap;
	logic               eof;
	logic               txd;
	logic [IDX_W-1:0]   txs;
	logic [ID_W-1:0]    rid;
	logic [DLC_W-1:0]   rdlc;
	logic [DATA_W-1:0]  rdat;
	logic [ST_W-1:0]    st;
	logic [ID_W-1:0]    id;
	logic [DATA_W-1:0]  dat;
	logic [DLC_W-1:0]   dlc;
	logic [PRI_W-1:0]   tx_priority_value;
	logic [NUM_BUF-1:0] txr;
	logic [NUM_BUF-1:0] pnd;
	logic               cb;
	int                 miscompares = 0;
	int                 n_tests = 0;

	cmb_can_node i_node (.clk_in(clk), .cap_out(cap), .id_out(rid), .dlc_out(rdlc),
		.data_out(rdat), .eof6_out(eof), .done_out(txd), .sel_out(txs));
	cmb_msg_buffers i_dut (.CLK_IN(clk), .RESETN_IN(rstn), .RECEIVE_BUFFER_LOCK_IN(lock),
		.GLOBAL_ACCEPT_MASK_IN(gm), .BASIC_ACCEPT_MASK_IN(bm), .RX_CAPTURE_IN(cap),
		.RX_ID_IN(rid), .RX_DLC_IN(rdlc), .RX_DATA_IN(rdat), .RX_EOF6_IN(eof),
		.CPU_WR_IN(wr), .CPU_SEL_IN(sel), .CPU_FIELD_IN(fld), .CPU_WDATA_IN(wd),
		.CPU_RD_SEL_IN(rsel), .RX_INT_ENABLE_IN(ie), .RX_INTERRUPT_PENDING_CLEAR_IN(pclr),
		.TX_DONE_IN(txd), .TX_DONE_SEL_IN(txs), .RD_STATUS_OUT(st), .RD_ID_OUT(id),
		.RD_DATA_OUT(dat), .RD_DLC_OUT(dlc), .RD_PRI_OUT(tx_priority_value), .TX_REQ_OUT(txr),
		.RX_INTERRUPT_PENDING_OUT(pnd), .COPY_BUSY_OUT(cb));

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic test_done();
		$display("TB: %0d compares, %0d mismatches", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic rd(input logic [IDX_W-1:0] s);
		@(negedge clk);
		rsel = s;
		@(negedge clk);
	endtask
	task automatic wr_f(input logic [IDX_W-1:0] s, input cmb_field_t f,
		input logic [DATA_W-1:0] d);
		@(negedge clk);
		{wr, sel, fld, wd} = {1'b1, s, f, d};
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic wt();
		repeat (20) @(negedge clk);
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		test_done();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		{rstn, lock, wr, sel, wd, rsel, pclr} = '0;
		{gm, bm, fld, ie} = {32'h000000F0, 32'hFFFFFFFF, FLD_STATUS, 15'h0001};
		repeat (12) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		for (int i = 0; i < NUM_BUF; i++) begin
			rd(IDX_W'(i));
			chk(st, ST_RX_IDLE);
		end
		$display("TB: reset test done");
		wr_f(4'h0, FLD_ID, 64'h100);
		wr_f(4'h1, FLD_ID, 64'h1F0);
		wr_f(4'h0, FLD_STATUS, 64'h2);
		wr_f(4'h1, FLD_STATUS, 64'h2);
		wr_f(4'hE, FLD_STATUS, 64'h2);
		i_node.frame(32'h000001F0, 4'h8, 64'h1122334455667788);
		rd(4'h0);
		chk(st, 4'h3);
		wt();
		rd(4'h0);
		chk({st, dlc, id, dat[15:0]}, {4'h4, 4'h8, 32'h1F0, 16'h7788});
		chk(pnd, 15'h0001);
		rd(4'h1);
		chk(st, ST_RX_ARMED);
		rd(4'hE);
		chk(st, ST_RX_ARMED);
		@(negedge clk);
		pclr = 15'h0001;
		@(negedge clk);
		pclr = '0;
		@(negedge clk);
		chk(pnd, 15'h0000);
		$display("TB: filter test done");
		i_node.frame(32'h00000180, 4'h2, 64'hA5);
		rd(4'h0);
		chk(st, 4'h5);
		wr_f(4'h0, FLD_CTRL, 64'hD0);
		wt();
		rd(4'h0);
		chk({st, dlc, id, tx_priority_value}, {4'h6, 4'h2, 32'h180, 4'h0});
		$display("TB: overrun test done");
		lock = 1'b1;
		wr_f(4'h0, FLD_STATUS, 64'h2);
		for (int k = 0; k < 4; k++) begin
			i_node.frame(32'h000001A0, 4'h8, 64'hF0 + k);
			wt();
		end
		rd(4'h0);
		chk({st, dat}, {4'h4, 64'hF0});
		rd(4'h1);
		chk({st, dat}, {4'h4, 64'hF1});
		rd(4'hE);
		chk({st, dat}, {4'h4, 64'hF2});
		$display("TB: lock test done");
		wr_f(4'h2, FLD_STATUS, 64'h8);
		wr_f(4'h2, FLD_DATA, 64'h55);
		wr_f(4'h2, FLD_CTRL, 64'h38);
		wr_f(4'h2, FLD_STATUS, 64'hC);
		wr_f(4'h2, FLD_DATA, 64'h99);
		rd(4'h2);
		chk({st, dat, tx_priority_value, dlc, txr[2]}, {4'hD, 64'h55, 4'h3, 4'h8, 1'b1});
		i_node.ack(4'h2);
		rd(4'h2);
		chk({st, txr[2]}, {ST_TX_IDLE, 1'b0});
		wr_f(4'h3, FLD_ID, 64'h301);
		wr_f(4'h3, FLD_STATUS, 64'hC);
		i_node.ack(4'h3);
		rd(4'h3);
		chk(st, ST_RX_ARMED);
		wr_f(4'h4, FLD_ID, 64'h401);
		wr_f(4'h4, FLD_STATUS, 64'hA);
		rd(4'h4);
		chk({st, txr[4]}, {ST_TX_AWAIT, 1'b0});
		i_node.frame(32'h00000401, 4'h0, 64'h0);
		wt();
		rd(4'h4);
		chk({st, txr[4]}, {4'hF, 1'b1});
		i_node.ack(4'h4);
		rd(4'h4);
		chk({st, txr[4]}, {ST_TX_AWAIT, 1'b0});
		wr_f(4'h5, FLD_STATUS, 64'hE);
		rd(4'h5);
		chk({st, txr[5]}, {4'hF, 1'b1});
		$display("TB: transmit test done");
		i_node.frame(32'h00000301, 4'h3, 64'h0);
		wt();
		rd(4'h3);
		chk({st, id, dlc}, {4'h4, 32'h301, 4'h3});
		$display("TB: remote receive test done");
		test_done();
	end
endmodule
